// ===== isq_consts.svh
`ifndef ISQ_CONSTS_SVH
`define ISQ_CONSTS_SVH
// Register byte addresses
`define ISQ_ADDR_CTRL_HI  8'h80
`define ISQ_ADDR_CTRL_LO  8'h81
`define ISQ_ADDR_START_HI 8'h82
`define ISQ_ADDR_START_MD 8'h83
`define ISQ_ADDR_START_LO 8'h84
`define ISQ_ADDR_STEP_HI  8'h85
`define ISQ_ADDR_STEP_MD  8'h86
`define ISQ_ADDR_STEP_LO  8'h87
`define ISQ_ADDR_PTS_HI   8'h88
`define ISQ_ADDR_PTS_LO   8'h89
`define ISQ_ADDR_SETL_HI  8'h8A
`define ISQ_ADDR_SETL_LO  8'h8B
`define ISQ_ADDR_STATUS   8'h8F
`define ISQ_ADDR_REAL_HI  8'h94
`define ISQ_ADDR_REAL_LO  8'h95
`define ISQ_ADDR_IMAG_HI  8'h96
`define ISQ_ADDR_IMAG_LO  8'h97
// Configuration window: high nibble and last low nibble
`define ISQ_CFG_PAGE      4'h8
`define ISQ_CFG_LAST      4'hB
// Command codes in the top nibble of the control high byte
`define ISQ_CMD_INIT      4'h1
`define ISQ_CMD_START     4'h2
`define ISQ_CMD_INCR      4'h3
`define ISQ_CMD_REPEAT    4'h4
`define ISQ_CMD_PDOWN     4'hA
`define ISQ_CMD_STBY      4'hB
// Field positions in the control high byte
`define ISQ_BIT_GAIN      0
`define ISQ_BIT_RANGE_LO  1
`define ISQ_BIT_RANGE_HI  2
// Status bit positions
`define ISQ_BIT_PDONE     2
`define ISQ_BIT_SDONE     3
// Reset value of every configuration byte
`define ISQ_CFG_RESET     8'h00
// Tone steps once every sixteen master clocks
`define ISQ_DDS_DIV_LAST  4'hF
// Last sample index of one transform
`define ISQ_DFT_LAST      10'h3FF
// Lowest accumulator bit kept in a result word
`define ISQ_RES_LSB       14
`endif

// ===== isq_host_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// Host side of the byte register port, standing in for the serial link
module isq_host_model (
    // Clock
    input  wire logic                    clock,
    // Byte register port toward the device
    output      isq_pkg::isq_regreq_type regReq,
    input  wire logic [7:0]              regRdData
);
    import isq_pkg::*;

    // Idle from time zero
    initial regReq = '0;

    ////////////////////////////////////////////////////////////////////
    // One byte write: taken at the rising edge after it is raised.
    // Idle address and data are inverted, never left on the last value.
    task automatic wrByte(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        regReq = '{addr: a, data: d, write: 1'b1, read: 1'b0};
        @(negedge clock);
        regReq = '{addr: ~a, data: ~d, write: 1'b0, read: 1'b0};
    endtask

    // One byte read: data stands from the edge after the request
    task automatic rdByte(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        regReq = '{addr: a, data: ~a, write: 1'b0, read: 1'b1};
        @(negedge clock);
        regReq = '{addr: ~a, data: a, write: 1'b0, read: 1'b0};
        d = regRdData;
    endtask
endmodule // isq_host_model

// ===== isq_pkg.sv
package isq_pkg;
    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        ISQ_OFF    = 6'b000001,
        ISQ_STBY   = 6'b000010,
        ISQ_INIT   = 6'b000100,
        ISQ_SETTLE = 6'b001000,
        ISQ_MEAS   = 6'b010000,
        ISQ_HOLD   = 6'b100000
    } isq_state_type;
    // Controls toward the analog front end
    typedef struct packed {
        logic [7:0] phase;
        logic [1:0] range;
        logic       gainFive;
        logic       pinsGrounded;
    } isq_tone_type;
    // One byte access from the serial interface
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic       write;
        logic       read;
    } isq_regreq_type;
endpackage

// ===== isq_sweep_sequencer.sv
`timescale 1ns/100ps
`include "isq_consts.svh"
module isq_sweep_sequencer #(
    parameter int PHASE_W = 27,
    parameter int FREQ_W  = 24,
    parameter int ADC_W   = 12,
    parameter int PTS_W   = 9,
    parameter int ACC_W   = 30
) (
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    // Byte register port
    input  wire isq_pkg::isq_regreq_type regReq,
    output      logic [7:0]              regRdData,
    // ADC samples
    input  wire logic                    adcValid,
    input  wire logic [ADC_W-1:0]        adcSample,
    output      logic                    adcGate,
    // Analog front end
    output      isq_pkg::isq_tone_type   toneOut
);
    import isq_pkg::*;

    ////////////////////////////////////////////////////////////
    // State
    logic [7:0]              cfg_reg [0:11];   // Bytes 0x80..0x8B
    isq_state_type           state_reg;        // Sequencer state
    isq_state_type           state_next;
    logic [FREQ_W-1:0]       curFreq_reg;      // Frequency in use
    logic [PTS_W-1:0]        pointIdx_reg;     // Steps taken
    logic                    pointDone_reg;    // Point measured
    logic                    sweepDone_reg;    // All points done
    logic [PHASE_W-1:0]      phase_reg;        // Tone phase
    logic [3:0]              divCnt_reg;       // Tone divider
    logic [15:0]             settleCnt_reg;    // Tone cycles seen
    logic [9:0]              sampleCnt_reg;    // Samples taken
    logic signed [ACC_W-1:0] accRe_reg;        // Real sum
    logic signed [ACC_W-1:0] accIm_reg;        // Imaginary sum
    logic [15:0]             realRes_reg;      // Real result
    logic [15:0]             imagRes_reg;      // Imaginary result
    logic [7:0]              rdData_reg;       // Read data
    isq_tone_type            tone_reg;         // Front end word

    // Fetch a configuration byte by its bus address
    function automatic logic [7:0] cfgByte(input logic [7:0] a);
        cfgByte = cfg_reg[a[3:0]];
    endfunction

    // Eight-step cosine table, scaled to a signed byte
    function automatic logic signed [7:0] cosLut(
        input logic [2:0] i);
        case (i)
            3'h0:    cosLut = 8'sh7F;
            3'h1:    cosLut = 8'sh5A;
            3'h2:    cosLut = 8'sh00;
            3'h3:    cosLut = 8'shA6;
            3'h4:    cosLut = 8'sh81;
            3'h5:    cosLut = 8'shA6;
            3'h6:    cosLut = 8'sh00;
            default: cosLut = 8'sh5A;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////
    // Register fields
    // start word bytes
    wire [FREQ_W-1:0] startFreq = {cfgByte(`ISQ_ADDR_START_HI),
        cfgByte(`ISQ_ADDR_START_MD), cfgByte(`ISQ_ADDR_START_LO)};
    wire [FREQ_W-1:0] stepFreq = {cfgByte(`ISQ_ADDR_STEP_HI),
        cfgByte(`ISQ_ADDR_STEP_MD), cfgByte(`ISQ_ADDR_STEP_LO)};
    wire [15:0] pointsWord = {cfgByte(`ISQ_ADDR_PTS_HI),
        cfgByte(`ISQ_ADDR_PTS_LO)};
    wire [PTS_W-1:0] numPoints = pointsWord[PTS_W-1:0];
    wire [15:0] settleTarget = {cfgByte(`ISQ_ADDR_SETL_HI),
        cfgByte(`ISQ_ADDR_SETL_LO)};
    wire [7:0] ctrlHi = cfgByte(`ISQ_ADDR_CTRL_HI);
    // Field names kept apart for readability
    wire rangeSelectHigh   = ctrlHi[`ISQ_BIT_RANGE_HI];
    wire rangeSelectLow    = ctrlHi[`ISQ_BIT_RANGE_LO];
    wire receiveGainSelect = ctrlHi[`ISQ_BIT_GAIN];

    ////////////////////////////////////////////////////////////
    // Bus decode
    wire       wrEn    = regReq.write;
    wire       cfgHit  = regReq.addr[7:4] == `ISQ_CFG_PAGE &&
                         regReq.addr[3:0] <= `ISQ_CFG_LAST;
    wire       wrCtrl  = wrEn && regReq.addr == `ISQ_ADDR_CTRL_HI;
    wire [3:0] cmdCode = regReq.data[7:4];
    wire cmdInit   = wrCtrl && cmdCode == `ISQ_CMD_INIT;
    wire cmdStart  = wrCtrl && cmdCode == `ISQ_CMD_START;
    wire cmdIncr   = wrCtrl && cmdCode == `ISQ_CMD_INCR;
    wire cmdRepeat = wrCtrl && cmdCode == `ISQ_CMD_REPEAT;
    wire cmdPdown  = wrCtrl && cmdCode == `ISQ_CMD_PDOWN;
    wire cmdStby   = wrCtrl && cmdCode == `ISQ_CMD_STBY;
    wire inStby  = state_reg == ISQ_STBY;
    wire inHold  = state_reg == ISQ_HOLD;
    // A start is only taken after standby or initialize
    wire startAcc = cmdStart &&
                    (inStby || state_reg == ISQ_INIT);
    // increments refused once the sweep is done
    wire incAcc = cmdIncr && inHold && !sweepDone_reg;
    // repeat stays on the current frequency
    wire repAcc = cmdRepeat && inHold;
    wire initAcc = cmdInit;

    ////////////////////////////////////////////////////////////
    // Tone generator
    wire tick    = divCnt_reg == `ISQ_DDS_DIV_LAST;
    // Phase is held at zero while the pins are grounded
    wire toneRun = !(inStby || state_reg == ISQ_OFF);
    wire [PHASE_W-1:0] phaseStep =
        {{(PHASE_W-FREQ_W){1'b0}}, curFreq_reg};
    wire [PHASE_W:0] phaseSum = {1'b0, phase_reg} +
                                {1'b0, phaseStep};
    wire wrap = tick && phaseSum[PHASE_W];
    wire [PHASE_W-1:0] phase_next = !toneRun ? '0 :
        (tick ? phaseSum[PHASE_W-1:0] : phase_reg);

    ////////////////////////////////////////////////////////////
    // Settling and transform
    // count whole tone cycles before sampling
    wire settleDone = settleCnt_reg >= settleTarget;
    wire [15:0] settleCnt_next =
        (state_reg != ISQ_SETTLE) ? 16'h0000 :
        (wrap ? settleCnt_reg + 16'h0001 : settleCnt_reg);
    wire sampleTake = state_reg == ISQ_MEAS && adcValid;
    // the last of 1024 samples ends the point
    wire measEnd = sampleTake && sampleCnt_reg == `ISQ_DFT_LAST;
    wire [2:0] refIdx = phase_reg[PHASE_W-1 -: 3];
    // Minus sine is the cosine a quarter turn later
    wire signed [7:0] cosRef = cosLut(refIdx);
    wire signed [7:0] sinNeg = cosLut(refIdx + 3'h2);
    wire signed [ADC_W+7:0] prodRe = $signed(adcSample) * cosRef;
    wire signed [ADC_W+7:0] prodIm = $signed(adcSample) * sinNeg;
    // First sample of a point restarts both sums
    wire signed [ACC_W-1:0] baseRe =
        sampleCnt_reg == 10'h000 ? '0 : accRe_reg;
    wire signed [ACC_W-1:0] baseIm =
        sampleCnt_reg == 10'h000 ? '0 : accIm_reg;
    wire signed [ACC_W-1:0] sumRe = baseRe + ACC_W'(prodRe);
    wire signed [ACC_W-1:0] sumIm = baseIm + ACC_W'(prodIm);

    ////////////////////////////////////////////////////////////
    // Sweep bookkeeping
    // step the frequency on each accepted increment
    wire [FREQ_W-1:0] curFreq_next =
        (initAcc || (startAcc && inStby)) ? startFreq :
        (incAcc ? FREQ_W'(curFreq_reg + stepFreq) : curFreq_reg);
    wire [PTS_W-1:0] pointIdx_next =
        (initAcc || startAcc) ? '0 :
        (incAcc ? PTS_W'(pointIdx_reg + 1'b1) : pointIdx_reg);
    // set wins over any clear in the same cycle
    wire pointDone_next = measEnd ? 1'b1 :
        ((incAcc || repAcc || initAcc || startAcc) ? 1'b0 :
         pointDone_reg);
    // last step reached when the count meets or passes the point count
    wire lastPoint = pointIdx_reg >= numPoints;
    wire sweepDone_next = (measEnd && lastPoint) ? 1'b1 :
        ((initAcc || startAcc) ? 1'b0 : sweepDone_reg);
    // two's complement slice of the sum
    wire [15:0] realRes_next = measEnd ?
        sumRe[`ISQ_RES_LSB +: 16] : realRes_reg;
    wire [15:0] imagRes_next = measEnd ?
        sumIm[`ISQ_RES_LSB +: 16] : imagRes_reg;

    ////////////////////////////////////////////////////////////
    // Read data
    wire [7:0] statusByte =
        (8'(sweepDone_reg) << `ISQ_BIT_SDONE) |
        (8'(pointDone_reg) << `ISQ_BIT_PDONE);
    // results readable at their byte pairs
    wire [7:0] rdByte =
        cfgHit ? cfgByte(regReq.addr) :
        regReq.addr == `ISQ_ADDR_STATUS  ? statusByte :
        regReq.addr == `ISQ_ADDR_REAL_HI ? realRes_reg[15:8] :
        regReq.addr == `ISQ_ADDR_REAL_LO ? realRes_reg[7:0] :
        regReq.addr == `ISQ_ADDR_IMAG_HI ? imagRes_reg[15:8] :
        regReq.addr == `ISQ_ADDR_IMAG_LO ? imagRes_reg[7:0] :
        8'h00;

    ////////////////////////////////////////////////////////////
    // Next state; mode commands override any sequence step
    always_comb begin
        state_next = state_reg;
        if (cmdPdown) begin
            state_next = ISQ_OFF;
        end else if (cmdStby) begin
            state_next = ISQ_STBY;
        end else if (initAcc) begin
            state_next = ISQ_INIT;
        end else begin
            case (state_reg)
                ISQ_OFF: begin
                    state_next = ISQ_OFF;
                end
                ISQ_STBY, ISQ_INIT: begin
                    // sweep begins on the start command
                    if (startAcc) state_next = ISQ_SETTLE;
                end
                ISQ_SETTLE: begin
                    if (settleDone) state_next = ISQ_MEAS;
                end
                ISQ_MEAS: begin
                    if (measEnd) state_next = ISQ_HOLD;
                end
                ISQ_HOLD: begin
                    // measure again after a step or repeat
                    if (incAcc || repAcc) state_next = ISQ_SETTLE;
                end
                default: begin
                    state_next = ISQ_OFF;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////
    // Configuration bytes; a command write also keeps its bits
    always_ff @(posedge clock) begin
        for (int i = 0; i < 12; i++) begin
            if (!rst_n) begin
                cfg_reg[i] <= `ISQ_CFG_RESET;
            end else if (wrEn && cfgHit && regReq.addr[3:0] == i) begin
                cfg_reg[i] <= regReq.data;
            end
        end
    end

    // Sequencer and tone
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg     <= ISQ_OFF;
            curFreq_reg   <= '0;
            pointIdx_reg  <= '0;
            phase_reg     <= '0;
            divCnt_reg    <= 4'h0;
            settleCnt_reg <= 16'h0000;
        end else begin
            state_reg     <= state_next;
            curFreq_reg   <= curFreq_next;
            pointIdx_reg  <= pointIdx_next;
            phase_reg     <= phase_next;
            divCnt_reg    <= divCnt_reg + 4'h1;
            settleCnt_reg <= settleCnt_next;
        end
    end

    // Transform sums and flags
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sampleCnt_reg <= 10'h000;
            accRe_reg     <= '0;
            accIm_reg     <= '0;
            pointDone_reg <= 1'b0;
            sweepDone_reg <= 1'b0;
        end else begin
            if (state_reg != ISQ_MEAS) begin
                sampleCnt_reg <= 10'h000;
            end else if (sampleTake) begin
                sampleCnt_reg <= sampleCnt_reg + 10'h001;
                accRe_reg     <= sumRe;
                accIm_reg     <= sumIm;
            end
            pointDone_reg <= pointDone_next;
            sweepDone_reg <= sweepDone_next;
        end
    end

    // Results, read data and front end word
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            realRes_reg <= 16'h0000;
            imagRes_reg <= 16'h0000;
            rdData_reg  <= 8'h00;
            tone_reg    <= '0;
        end else begin
            realRes_reg <= realRes_next;
            imagRes_reg <= imagRes_next;
            if (regReq.read) rdData_reg <= rdByte;
            tone_reg.phase        <= phase_reg[PHASE_W-1 -: 8];
            // amplitude range from the two range bits
            tone_reg.range        <= {rangeSelectHigh,
                                      rangeSelectLow};
            tone_reg.gainFive     <= !receiveGainSelect;
            // ground while the tone is stopped
            tone_reg.pinsGrounded <= !toneRun;
        end
    end

    assign regRdData = rdData_reg;
    assign toneOut   = tone_reg;
    // Gate is straight from the state flop
    assign adcGate   = state_reg == ISQ_MEAS;

    ////////////////////////////////////////////////////////////
    // Checks
    a_msb_zero: assert property (
        @(posedge clock) disable iff (!rst_n)
        phaseStep[PHASE_W-1:FREQ_W] == '0)
        else $error("frequency top bits not zero");

    a_point_done_set: assert property (
        @(posedge clock) disable iff (!rst_n)
        measEnd |=> pointDone_reg && state_reg == ISQ_HOLD)
        else $error("point done not raised");

    a_done_blocks_step: assert property (
        @(posedge clock) disable iff (!rst_n)
        sweepDone_reg && cmdIncr |=> $stable(curFreq_reg))
        else $error("step taken after sweep done");

    a_step_adds: assert property (
        @(posedge clock) disable iff (!rst_n)
        incAcc |=> curFreq_reg ==
            FREQ_W'($past(curFreq_reg) + $past(stepFreq)))
        else $error("increment did not add step");

    a_gate_after_settle: assert property (
        @(posedge clock) disable iff (!rst_n)
        $rose(adcGate) |-> $past(state_reg) == ISQ_SETTLE &&
            $past(settleDone))
        else $error("sampling before settling");

    a_sample_total: assert property (
        @(posedge clock) disable iff (!rst_n)
        measEnd |-> sampleCnt_reg == `ISQ_DFT_LAST && adcGate)
        else $error("point ended at wrong count");

    a_result_latch: assert property (
        @(posedge clock) disable iff (!rst_n)
        measEnd |=> realRes_reg == $past(sumRe[`ISQ_RES_LSB +: 16])
            && imagRes_reg == $past(sumIm[`ISQ_RES_LSB +: 16]))
        else $error("result not latched");

    a_repeat_clear: assert property (
        @(posedge clock) disable iff (!rst_n)
        repAcc |=> !pointDone_reg ##0 $stable(curFreq_reg))
        else $error("repeat did not clear flag");

    a_standby_ground: assert property (
        @(posedge clock) disable iff (!rst_n)
        cmdStby && !cmdPdown |=> ##2 toneOut.pinsGrounded)
        else $error("standby did not ground pins");

    a_gain_follow: assert property (
        @(posedge clock) disable iff (!rst_n)
        wrCtrl |=> ##1 toneOut.gainFive ==
            !$past(regReq.data[`ISQ_BIT_GAIN], 2))
        else $error("gain select not applied");

endmodule // isq_sweep_sequencer

// ===== isq_sweep_sequencer_test.sv
`timescale 1ns/100ps
`include "isq_consts.svh"
////////////////////////////////////////////////////////////////////////
// Self-checking bench for the sweep sequencer
module isq_sweep_sequencer_test;
    import isq_pkg::*;

    logic           clock;        // Master clock, 100 MHz
    logic           rst_n;        // Synchronous reset, active low
    isq_regreq_type regReq;       // Driven by the host model
    logic [7:0]     regRdData;    // Read byte
    logic           adcValid;     // Conversion strobe, every other cycle
    logic [11:0]    adcSample;    // Sample value
    logic           adcGate;      // Sampling window from the device
    isq_tone_type   toneOut;      // Front-end controls
    int             n_errors;     // Mismatches
    int             compares;     // Comparisons made
    int             nSamp;        // Samples taken in the window
    logic           gateSeen;     // Window opened since last clear
    logic [7:0]     rd;           // Scratch read byte
    logic [7:0]     cfgAddr [10]; // Configuration table
    logic [7:0]     cfgData [10];

    isq_sweep_sequencer dut (
        .clock     (clock),
        .rst_n     (rst_n),
        .regReq    (regReq),
        .regRdData (regRdData),
        .adcValid  (adcValid),
        .adcSample (adcSample),
        .adcGate   (adcGate),
        .toneOut   (toneOut)
    );

    isq_host_model host (
        .clock     (clock),
        .regReq    (regReq),
        .regRdData (regRdData)
    );

    ////////////////////////////////////////////////////////////////////
    // master clock and converter strobe, strobe off the edge
    initial clock = 1'b0;
    always #5 clock = ~clock;
    always @(negedge clock) adcValid <= ~adcValid;

    // Count samples actually taken and note any opened window
    always @(posedge clock) begin
        if (adcGate === 1'b1 && adcValid === 1'b1)
            nSamp++;
        if (adcGate === 1'b1)
            gateSeen = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] exp,
                         input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic test_done();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Poll status until the point ends; bounded so a hang ends the run
    task automatic waitPoint();
        for (int i = 0; i < 4000; i++) begin
            host.rdByte(`ISQ_ADDR_STATUS, rd);
            if (rd[`ISQ_BIT_PDONE] === 1'b1)
                return;
        end
        n_errors++;
        $display("ERROR point_done expected 1 seen timeout");
        test_done();
    endtask

    // Measure one point and check sample count and status flags
    task automatic measure(input logic [7:0] cmd, input logic [7:0] st);
        nSamp = 0;
        host.wrByte(`ISQ_ADDR_CTRL_HI, cmd);
        // Flags fall as soon as a new measurement starts
        host.rdByte(`ISQ_ADDR_STATUS, rd);
        check("flags_cleared", 16'h0000, {8'h00, rd & 8'h0C});
        waitPoint();
        check("sample_count", 16'h0400, nSamp[15:0]);
        host.rdByte(`ISQ_ADDR_STATUS, rd);
        check("status_flags", {8'h00, st}, {8'h00, rd & 8'h0C});
    endtask

    // Read both result words as the host must before moving on
    task automatic readResults(output logic [31:0] r);
        for (int i = 0; i < 4; i++) begin
            host.rdByte(`ISQ_ADDR_REAL_HI + 8'(i), rd);
            r = {r[23:0], rd};
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] res;
        n_errors = 0;
        compares = 0;
        nSamp = 0;
        gateSeen = 1'b0;
        rst_n = 1'b0;
        adcValid = 1'b0;
        adcSample = 12'h000;
        cfgAddr = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87,
                    8'h88, 8'h89, 8'h8A, 8'h8B};
        cfgData = '{8'h3D, 8'h70, 8'hA3, 8'h00, 8'h05, 8'h3E,
                    8'h01, 8'hFF, 8'h00, 8'h02};
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        // Reset values, unmapped and read-only places
        host.rdByte(`ISQ_ADDR_START_HI, rd);
        check("start_reset", 16'h0000, {8'h00, rd});
        host.rdByte(8'h90, rd);
        check("unmapped", 16'h0000, {8'h00, rd});
        host.wrByte(`ISQ_ADDR_REAL_HI, 8'hFF);
        host.wrByte(`ISQ_ADDR_STATUS, 8'hFF);
        host.rdByte(`ISQ_ADDR_REAL_HI, rd);
        check("real_readonly", 16'h0000, {8'h00, rd});
        host.rdByte(`ISQ_ADDR_STATUS, rd);
        check("status_readonly", 16'h0000, {8'h00, rd});
        // Configuration bytes, point count at its 511 ceiling
        foreach (cfgAddr[i]) host.wrByte(cfgAddr[i], cfgData[i]);
        foreach (cfgAddr[i]) begin
            host.rdByte(cfgAddr[i], rd);
            check("cfg_byte", {8'h00, cfgData[i]}, {8'h00, rd});
        end
        // Every range code and both gains, in standby
        for (int r = 0; r < 4; r++) begin
            host.wrByte(`ISQ_ADDR_CTRL_HI, {4'hB, 1'b0, 2'(r), r[0]});
            @(negedge clock);
            check("range", 16'(r), {14'h0000, toneOut.range});
            check("gain", {15'h0000, ~r[0]}, 16'(toneOut.gainFive));
            check("grounded", 16'h0001, 16'(toneOut.pinsGrounded));
            check("phase_idle", 16'h0000, {8'h00, toneOut.phase});
        end
        // Two points; start word near half scale keeps wraps short,
        // and stays fast once the step has been added
        host.wrByte(`ISQ_ADDR_PTS_HI, 8'h00);
        host.wrByte(`ISQ_ADDR_PTS_LO, 8'h01);
        host.wrByte(`ISQ_ADDR_START_HI, 8'h7F);
        host.wrByte(`ISQ_ADDR_START_MD, 8'hFF);
        host.wrByte(`ISQ_ADDR_START_LO, 8'hFF);
        // Initialize drives the tone but opens no window
        host.wrByte(`ISQ_ADDR_CTRL_HI, 8'h10);
        gateSeen = 1'b0;
        repeat (300) @(negedge clock);
        check("init_no_gate", 16'h0000, 16'(gateSeen));
        check("init_pins", 16'h0000, 16'(toneOut.pinsGrounded));
        // Start: two settling wraps of about 256 clocks come first
        gateSeen = 1'b0;
        fork
            measure(8'h20, 8'h04);
            begin
                repeat (100) @(negedge clock);
                check("settle_wait", 16'h0000, 16'(gateSeen));
            end
        join
        readResults(res);
        check("zero_real", 16'h0000, res[31:16]);
        check("zero_imag", 16'h0000, res[15:0]);
        // Repeat the point, then step to the last one
        adcSample = 12'h5A5;
        measure(8'h40, 8'h04);
        readResults(res);
        measure(8'h30, 8'h0C);
        // A further increment opens no window
        host.wrByte(`ISQ_ADDR_CTRL_HI, 8'h30);
        gateSeen = 1'b0;
        // A taken increment would clear the point-done flag at once
        host.rdByte(`ISQ_ADDR_STATUS, rd);
        check("incr_refused", 16'h000C, {8'h00, rd & 8'h0C});
        // Long enough to cover two settling wraps of a taken step
        repeat (600) @(negedge clock);
        check("incr_ignored", 16'h0000, 16'(gateSeen));
        host.wrByte(`ISQ_ADDR_CTRL_HI, 8'hA0);
        repeat (2) @(negedge clock);
        check("pdown_pins", 16'h0001, 16'(toneOut.pinsGrounded));
        test_done();
    end
endmodule // isq_sweep_sequencer_test
